// File: rtl/lbrg_arbiter.sv
// Device-side request/grant logic for the shared local-memory bus
`timescale 1ns/10ps
// Functional notes
// R1: Bus cycles start only while the active-low grant input is low.
// R2: Grant high forces the device to give up the bus.
// R3: Arbiter grants by driving grant low, withdraws by driving it high.
// R4: Request code LL is high priority, HL is low priority.
// R5: Code LH signals termination while the current access completes.
// R6: Serial transfers and host accesses request at high priority.
// R7: Refresh requests high when twelve or more pending, else low.
// R8: Own processor accesses request at low priority.
// R9: Arbiter should grant high-priority requests as soon as possible.
// R10: Code HH when no further bus cycles are needed.
// R11: Grant is sampled on the clock; release only at cycle boundaries.
module lbrg_arbiter (
  input wire logic i_clk, // 125 MHz clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic i_bus_grant_in_n, // Grant pin, active low
  input wire lbrg_pkg::lbrg_need_t i_need, // Access causes pending
  input wire logic [4:0] i_refresh_pending, // Pending refresh count
  output logic o_bus_request_code_hi_n, // Request code upper line
  output logic o_bus_request_code_lo_n, // Request code lower line
  output logic o_bus_owned, // Device owns bus
  output logic o_cycle_start, // Pulse: bus cycle begins
  output logic o_cycle_end // Pulse: last beat of bus cycle
);
  lbrg_pkg::lbrg_regs_t r_ff;
  lbrg_pkg::lbrg_regs_t nxt_r;
  logic grant_ok;
  logic any_need;
  logic high_pri;
  logic [1:0] req_code;

  // Filtered grant: second and third stages agree
  always_comb begin
    grant_ok = r_ff.granted;
    if (r_ff.grant_sync[1] == r_ff.grant_sync[2]) begin
      grant_ok = ~r_ff.grant_sync[2]; // [R3]
    end
  end

  always_comb begin
    high_pri = i_need.serial_xfer | i_need.host_access; // [R6]
    if (i_refresh_pending >= lbrg_pkg::REFRESH_HIGH_LEVEL) begin
      high_pri = 1'b1; // [R7]
    end
    any_need = high_pri | i_need.cpu_access | (i_refresh_pending != 5'h00); // [R8]
    if (!any_need) begin
      req_code = lbrg_pkg::CODE_NONE; // [R10]
    end else if (high_pri) begin
      req_code = lbrg_pkg::CODE_HIGH; // [R4]
    end else begin
      req_code = lbrg_pkg::CODE_LOW; // [R4]
    end
  end

  always_comb begin
    nxt_r = r_ff;
    nxt_r.grant_sync = {r_ff.grant_sync[1:0], i_bus_grant_in_n};
    nxt_r.granted = grant_ok;
    case (r_ff.state)
      lbrg_pkg::LBRG_IDLE: begin
        nxt_r.code = req_code;
        if (any_need) begin
          nxt_r.state = lbrg_pkg::LBRG_WAIT;
        end
      end
      lbrg_pkg::LBRG_WAIT: begin
        nxt_r.code = req_code;
        if (!any_need) begin
          nxt_r.state = lbrg_pkg::LBRG_IDLE;
        end else if (grant_ok) begin
          nxt_r.state = lbrg_pkg::LBRG_CYCLE; // [R1]
          nxt_r.cyc_cnt = 3'h0;
          nxt_r.busy = 1'b1;
        end
      end
      lbrg_pkg::LBRG_CYCLE: begin
        nxt_r.cyc_cnt = r_ff.cyc_cnt + 3'h1;
        if (r_ff.cyc_cnt == lbrg_pkg::CYC_LAST - 3'h1) begin
          nxt_r.code = lbrg_pkg::CODE_TERM; // [R5]
          nxt_r.state = lbrg_pkg::LBRG_TERM;
        end
      end
      lbrg_pkg::LBRG_TERM: begin
        // Boundary: hold bus only if still granted and needed
        nxt_r.cyc_cnt = 3'h0;
        nxt_r.code = req_code;
        if (grant_ok && any_need) begin
          nxt_r.state = lbrg_pkg::LBRG_CYCLE; // [R11]
        end else begin
          nxt_r.busy = 1'b0; // [R2] [R11]
          nxt_r.state = any_need ? lbrg_pkg::LBRG_WAIT : lbrg_pkg::LBRG_IDLE;
        end
      end
      default: begin
        nxt_r.state = lbrg_pkg::LBRG_IDLE;
        nxt_r.busy = 1'b0;
        nxt_r.code = lbrg_pkg::CODE_NONE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_ff.state <= lbrg_pkg::LBRG_IDLE;
      r_ff.cyc_cnt <= 3'h0;
      r_ff.code <= lbrg_pkg::CODE_NONE;
      r_ff.grant_sync <= 3'h7;
      r_ff.granted <= 1'b0;
      r_ff.busy <= 1'b0;
    end else if (i_ce) begin
      r_ff <= nxt_r;
    end
  end

  assign o_bus_request_code_hi_n = r_ff.code[1];
  assign o_bus_request_code_lo_n = r_ff.code[0];
  assign o_bus_owned = r_ff.busy;
  assign o_cycle_start = i_ce && r_ff.state == lbrg_pkg::LBRG_CYCLE &&
                         r_ff.cyc_cnt == 3'h0;
  assign o_cycle_end = i_ce && r_ff.state == lbrg_pkg::LBRG_TERM;

  // Filter may bridge a one-cycle glitch, so look one sample back too
  property p_start_needs_grant;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && r_ff.state == lbrg_pkg::LBRG_WAIT && nxt_r.state == lbrg_pkg::LBRG_CYCLE)
      |-> !r_ff.grant_sync[2] || !$past(r_ff.grant_sync[2]);
  endproperty
  a_start_needs_grant: assert property (p_start_needs_grant) else $error("start without grant"); // [R1]

  property p_release_at_end;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && r_ff.state == lbrg_pkg::LBRG_TERM && !grant_ok) |=> !o_bus_owned;
  endproperty
  a_release_at_end: assert property (p_release_at_end) else $error("bus kept without grant"); // [R2]

  property p_term_code;
    @(posedge i_clk) disable iff (!i_rstn)
      r_ff.state == lbrg_pkg::LBRG_TERM |->
        {o_bus_request_code_hi_n, o_bus_request_code_lo_n} == 2'b01;
  endproperty
  a_term_code: assert property (p_term_code) else $error("no termination code"); // [R5]

  property p_high_code;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && r_ff.state == lbrg_pkg::LBRG_WAIT && (i_need.host_access || i_need.serial_xfer))
      |=> {o_bus_request_code_hi_n, o_bus_request_code_lo_n} == 2'b00;
  endproperty
  a_high_code: assert property (p_high_code) else $error("host/serial not high"); // [R6]

  property p_refresh_code;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && r_ff.state == lbrg_pkg::LBRG_WAIT && !i_need.host_access &&
       !i_need.serial_xfer && i_refresh_pending != 5'h00)
      |=> o_bus_request_code_hi_n == ($past(i_refresh_pending) < lbrg_pkg::REFRESH_HIGH_LEVEL);
  endproperty
  a_refresh_code: assert property (p_refresh_code) else $error("refresh priority wrong"); // [R7]

  property p_cpu_low;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && r_ff.state == lbrg_pkg::LBRG_WAIT && i_need.cpu_access &&
       !i_need.host_access && !i_need.serial_xfer && i_refresh_pending == 5'h00)
      |=> {o_bus_request_code_hi_n, o_bus_request_code_lo_n} == 2'b10;
  endproperty
  a_cpu_low: assert property (p_cpu_low) else $error("cpu not low priority"); // [R8] [R4]

  property p_none_code;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && r_ff.state == lbrg_pkg::LBRG_IDLE && !any_need)
      |=> {o_bus_request_code_hi_n, o_bus_request_code_lo_n} == 2'b11;
  endproperty
  a_none_code: assert property (p_none_code) else $error("idle code not HH"); // [R10]

  property p_cycle_len;
    @(posedge i_clk) disable iff (!i_rstn)
      (o_cycle_start && i_ce) |=> (o_bus_owned && !o_cycle_end) [*1] ##1 o_bus_owned;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle cut short"); // [R11]

  // Framing, ownership and enable checks
  property p_ce_freeze;
    @(posedge i_clk) disable iff (!i_rstn)
      !i_ce |=> $stable(r_ff);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while disabled"); // [R11]

  property p_start_owned;
    @(posedge i_clk) disable iff (!i_rstn)
      o_cycle_start |-> o_bus_owned;
  endproperty
  a_start_owned: assert property (p_start_owned) else $error("cycle start without bus"); // [R1]

  property p_term_beat;
    @(posedge i_clk) disable iff (!i_rstn)
      r_ff.state == lbrg_pkg::LBRG_TERM |-> r_ff.cyc_cnt == lbrg_pkg::CYC_LAST;
  endproperty
  a_term_beat: assert property (p_term_beat) else $error("termination off boundary"); // [R11]

  property p_owned_code;
    @(posedge i_clk) disable iff (!i_rstn)
      o_bus_owned |->
        {o_bus_request_code_hi_n, o_bus_request_code_lo_n} != lbrg_pkg::CODE_NONE;
  endproperty
  a_owned_code: assert property (p_owned_code) else $error("bus held with no request"); // [R10]

  property p_release_at_term;
    @(posedge i_clk) disable iff (!i_rstn)
      $fell(o_bus_owned) |-> $past(r_ff.state) == lbrg_pkg::LBRG_TERM;
  endproperty
  a_release_at_term: assert property (p_release_at_term) else $error("released mid-cycle"); // [R11]

  property p_wait_not_owned;
    @(posedge i_clk) disable iff (!i_rstn)
      r_ff.state == lbrg_pkg::LBRG_WAIT |-> !o_bus_owned;
  endproperty
  a_wait_not_owned: assert property (p_wait_not_owned) else $error("bus held while waiting"); // [R2]

  c_grant: cover property (@(posedge i_clk) disable iff (!i_rstn) o_cycle_start);
  c_release: cover property (@(posedge i_clk) disable iff (!i_rstn)
    $fell(o_bus_owned));
  c_back: cover property (@(posedge i_clk) disable iff (!i_rstn)
    o_cycle_end ##1 o_cycle_start);
  c_high_start: cover property (@(posedge i_clk) disable iff (!i_rstn)
    o_cycle_start && !o_bus_request_code_hi_n && !o_bus_request_code_lo_n);
  c_frozen: cover property (@(posedge i_clk) disable iff (!i_rstn)
    !i_ce && any_need);
endmodule

// File: rtl/lbrg_pkg.sv
// Package: request codes, states and carriers for the local bus request/grant block
package lbrg_pkg;
  // Request code {hi_n, lo_n}
  localparam logic [1:0] CODE_HIGH = 2'h0;
  localparam logic [1:0] CODE_TERM = 2'h1;
  localparam logic [1:0] CODE_LOW = 2'h2;
  localparam logic [1:0] CODE_NONE = 2'h3;
  localparam int REFRESH_HIGH_THRESHOLD = 12;
  localparam int REFRESH_CNT_W = 5;
  localparam logic [4:0] REFRESH_HIGH_LEVEL = 5'h0C;
  localparam int BUS_CYCLE_LEN = 4;
  localparam int CYC_CNT_W = 3;
  localparam logic [2:0] CYC_LAST = 3'h3;

  typedef enum logic [1:0] {
    LBRG_IDLE = 2'b00,
    LBRG_WAIT = 2'b01,
    LBRG_CYCLE = 2'b11,
    LBRG_TERM = 2'b10
  } lbrg_state_t;

  typedef struct packed {
    logic serial_xfer;
    logic host_access;
    logic cpu_access;
  } lbrg_need_t;

  typedef struct packed {
    lbrg_state_t state;
    logic [2:0] cyc_cnt;
    logic [1:0] code;
    logic [2:0] grant_sync;
    logic granted;
    logic busy;
  } lbrg_regs_t;
endpackage

// File: bench/lbrg_arb_model.sv
// Far-side bus arbitration model driving the grant pin
`timescale 1ns/10ps
module lbrg_arb_model (
  input wire logic i_clk, // Bus clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_allow, // Bench permits granting
  input wire logic [1:0] i_code, // Device request code
  output logic o_grant_n // Grant pin, active low
);
  logic grant_n_ff;
  logic low_wait_ff;
  assign o_grant_n = grant_n_ff;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      grant_n_ff <= 1'b1;
      low_wait_ff <= 1'b0;
    end else begin
      low_wait_ff <= (i_code == lbrg_pkg::CODE_LOW);
      if (!i_allow || i_code == lbrg_pkg::CODE_NONE) begin
        grant_n_ff <= 1'b1;
      end else if (i_code == lbrg_pkg::CODE_HIGH) begin
        grant_n_ff <= 1'b0;
      end else if (i_code == lbrg_pkg::CODE_LOW && low_wait_ff) begin
        grant_n_ff <= 1'b0; // Slow answer to low priority
      end
    end
  end
endmodule

// File: bench/tb.sv
// Testbench for the local bus request/grant block
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    lbrg_pkg::lbrg_need_t nd;
    logic [4:0] rf;
    logic [1:0] code;
  } lbrg_row_t;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic allow = 1'b0;
  logic en = 1'b1;
  logic grant_n, hi_n, lo_n, owned, cs, ce;
  lbrg_pkg::lbrg_need_t need = 3'h0;
  logic [4:0] refr = 5'h00;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int starts = 0;
  int n;
  lbrg_row_t rows[8] = '{'{3'h4, 5'h00, 2'h0}, '{3'h2, 5'h00, 2'h0}, '{3'h1, 5'h00, 2'h2},
    '{3'h0, 5'h0C, 2'h0}, '{3'h0, 5'h0B, 2'h2}, '{3'h0, 5'h1F, 2'h0}, '{3'h1, 5'h0C, 2'h0},
    '{3'h0, 5'h01, 2'h2}};
  always #4 i_clk = ~i_clk;
  lbrg_arbiter dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(en), .i_bus_grant_in_n(grant_n),
    .i_need(need), .i_refresh_pending(refr), .o_bus_request_code_hi_n(hi_n),
    .o_bus_request_code_lo_n(lo_n), .o_bus_owned(owned), .o_cycle_start(cs), .o_cycle_end(ce));
  lbrg_arb_model arb (.i_clk(i_clk), .i_rstn(i_rstn), .i_allow(allow), .i_code({hi_n, lo_n}),
    .o_grant_n(grant_n));
  task automatic print_verdict;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Wait bounded for a pulse: 0 cycle start, 1 cycle end
  task automatic w(input logic which, input int lim);
    for (int i = 0; i < lim; i++) begin
      if ((which ? ce : cs) === 1'b1) break;
      @(negedge i_clk);
    end
    chk("pulse", 2'h1, {1'b0, which ? ce : cs});
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cs === 1'b1) starts++;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(negedge i_clk);
    i_rstn = 1'b1;
    chk("code", lbrg_pkg::CODE_NONE, {hi_n, lo_n});
    foreach (rows[i]) begin
      need = rows[i].nd;
      refr = rows[i].rf;
      repeat (2) @(negedge i_clk);
      chk("code", rows[i].code, {hi_n, lo_n});
      need = 3'h0;
      refr = 5'h00;
      repeat (2) @(negedge i_clk);
      chk("idle", lbrg_pkg::CODE_NONE, {hi_n, lo_n});
    end
    chk("starts", 2'h0, {1'b0, starts != 0});
    need = 3'h2;
    en = 1'b0;
    repeat (3) @(negedge i_clk);
    chk("frozen", lbrg_pkg::CODE_NONE, {hi_n, lo_n});
    en = 1'b1;
    repeat (2) @(negedge i_clk);
    chk("code", lbrg_pkg::CODE_HIGH, {hi_n, lo_n});
    need = 3'h0;
    repeat (2) @(negedge i_clk);
    chk("idle", lbrg_pkg::CODE_NONE, {hi_n, lo_n});
    $display("table done");
    allow = 1'b1;
    need = 3'h1;
    w(1'b0, 20);
    chk("owned", 2'h1, {1'b0, owned});
    repeat (lbrg_pkg::BUS_CYCLE_LEN - 1) @(negedge i_clk);
    chk("end", 2'h1, {1'b0, ce});
    chk("term", lbrg_pkg::CODE_TERM, {hi_n, lo_n});
    w(1'b0, 12);
    allow = 1'b0;
    @(negedge i_clk);
    chk("owned", 2'h1, {1'b0, owned});
    w(1'b1, 6);
    chk("owned", 2'h1, {1'b0, owned});
    repeat (12) @(negedge i_clk);
    n = starts;
    repeat (10) @(negedge i_clk);
    chk("starts", 2'h0, {1'b0, starts != n});
    chk("owned", 2'h0, {1'b0, owned});
    chk("code", lbrg_pkg::CODE_LOW, {hi_n, lo_n});
    need = 3'h0;
    repeat (3) @(negedge i_clk);
    chk("code", lbrg_pkg::CODE_NONE, {hi_n, lo_n});
    $display("cycle tests done");
    // Reset on the first beat of an owned cycle
    allow = 1'b1;
    need = 3'h4;
    w(1'b0, 20);
    i_rstn = 1'b0;
    @(negedge i_clk);
    chk("rst", lbrg_pkg::CODE_NONE, {hi_n, lo_n});
    chk("rst", 2'h0, {1'b0, owned});
    i_rstn = 1'b1;
    @(negedge i_clk);
    chk("rst1", lbrg_pkg::CODE_HIGH, {hi_n, lo_n});
    chk("rst1", 2'h0, {1'b0, owned});
    @(negedge i_clk);
    chk("rst2", 2'h0, {1'b0, owned});
    w(1'b0, 20);
    chk("owned", 2'h1, {1'b0, owned});
    $display("reset test done");
    print_verdict();
  end
endmodule
